// ### preload_pkg.sv
/*
  Shared constants for the output register preload and power-up clear logic.
  Assumes a single 125 MHz clock domain and ten output macrocells.
*/
package preload_pkg;
  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int NUM_OUT = 10;
  localparam int SYNC_STAGES = 3;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [9:0] OUT_REG_RST = 10'h000;
  localparam logic [2:0] SYNC_RST = 3'h0;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int SETUP_TIME_NS = 25;
  localparam int SETUP_CYCLES = (SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] SETUP_CNT_INIT = 3'(SETUP_CYCLES);
endpackage

// ### pin_sync.sv
/*
  Three-stage synchroniser with agreement filter for one pin input.
  Assumes the pin is asynchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import preload_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_sync_n,
  input wire logic clk_en,
  input wire logic pin,
  output logic level
);
  // ----------------------------------------
  // Sync chain
  // ----------------------------------------
  logic [2:0] sync_r;
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sync_r <= SYNC_RST;
    end else if (clk_en) begin
      sync_r <= {sync_r[1:0], pin};
    end
  end
  // ----------------------------------------
  // Agreement filter
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      level <= 1'b0;
    end else if (clk_en && (sync_r[1] == sync_r[2])) begin
      level <= sync_r[2];
    end
  end
endmodule
`default_nettype wire

// ### output_register_preload_init.sv
/*
  Registered output macrocells with tester preload and power-up clear.
  Assumes pins are sampled on mclk; the device clock pin and the preload
  supervoltage detector are asynchronous inputs; array logic is outside.
*/
// Contract
// - Preload loads one register per pass (code loads every registered output whose preload_sel bit is set)
// - Clock pulse captures driven pin level
// - Preloaded state shown on output pin
// - Power-up clears all registers without clock
// - Pin level is cleared value through polarity
// - Clear zeroes io_out and io_oe of every pin, not only registered outputs
`timescale 1ns/1ps
`default_nettype none
module output_register_preload_init
  import preload_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic dev_clk_pin,
  input wire logic preload_supervoltage_level,
  input wire logic [9:0] preload_sel,
  input wire logic [9:0] io_in,
  input wire logic [9:0] array_d,
  input wire logic [9:0] comb_d,
  input wire logic [9:0] registered_cfg,
  input wire logic [9:0] invert_cfg,
  input wire logic [9:0] oe_term,
  output logic [9:0] io_out,
  output logic [9:0] io_oe,
  output logic [9:0] out_reg_q,
  output logic setup_ready
);
  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_pipe_r;
  logic rst_sync_n;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_r <= 2'h0;
    end else begin
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe_r[1];

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic clk_lvl;
  logic pre_lvl;
  logic [9:0] io_lvl;
  pin_sync u_clk_sync (.mclk(mclk), .rst_sync_n(rst_sync_n), .clk_en(clk_en), .pin(dev_clk_pin), .level(clk_lvl));
  pin_sync u_pre_sync (.mclk(mclk), .rst_sync_n(rst_sync_n), .clk_en(clk_en),
    .pin(preload_supervoltage_level), .level(pre_lvl));
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_io
      pin_sync u_io_sync (.mclk(mclk), .rst_sync_n(rst_sync_n), .clk_en(clk_en), .pin(io_in[gi]), .level(io_lvl[gi]));
    end
  endgenerate

  // ----------------------------------------
  // Clock edge detect
  // ----------------------------------------
  logic clk_prev_r;
  logic clk_rise;
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      clk_prev_r <= 1'b0;
    end else if (clk_en) begin
      clk_prev_r <= clk_lvl;
    end
  end
  assign clk_rise = clk_lvl && !clk_prev_r && clk_en;

  // ----------------------------------------
  // Setup guard after clear
  // ----------------------------------------
  logic [2:0] setup_cnt_r;
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      setup_cnt_r <= SETUP_CNT_INIT;
    end else if (clk_en && setup_cnt_r != 3'h0) begin
      setup_cnt_r <= setup_cnt_r - 3'h1;
    end
  end
  assign setup_ready = (setup_cnt_r == 3'h0);

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  logic [9:0] sel_one;
  assign sel_one = preload_sel & registered_cfg;
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      out_reg_q <= OUT_REG_RST;
    end else if (clk_rise && setup_ready) begin
      if (pre_lvl) begin
        out_reg_q <= (out_reg_q & ~sel_one) | (io_lvl & sel_one);
      end else begin
        out_reg_q <= array_d;
      end
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      io_out <= OUT_REG_RST;
      io_oe <= OUT_REG_RST;
    end else if (clk_en) begin
      // Registered vs combinational macrocell, then polarity
      io_out <= (registered_cfg & out_reg_q | ~registered_cfg & comb_d) ^ invert_cfg;
      io_oe <= pre_lvl ? (~registered_cfg & oe_term) : oe_term;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_clear_zero;
    @(posedge mclk) $rose(rst_sync_n) |-> out_reg_q == 10'h000;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("registers not cleared");
  property p_capture;
    @(posedge mclk) disable iff (!rst_sync_n)
      (clk_rise && setup_ready && pre_lvl) |=> ((out_reg_q & $past(sel_one)) == ($past(io_lvl) & $past(sel_one)));
  endproperty
  a_capture: assert property (p_capture) else $error("preload capture wrong");
  property p_one_only;
    @(posedge mclk) disable iff (!rst_sync_n)
      (clk_rise && setup_ready && pre_lvl) |=> ((out_reg_q & ~$past(sel_one)) == ($past(out_reg_q) & ~$past(sel_one)));
  endproperty
  a_one_only: assert property (p_one_only) else $error("unselected register changed");
  property p_normal;
    @(posedge mclk) disable iff (!rst_sync_n)
      (clk_rise && setup_ready && !pre_lvl) |=> out_reg_q == $past(array_d);
  endproperty
  a_normal: assert property (p_normal) else $error("normal clocking wrong");
  property p_show;
    @(posedge mclk) disable iff (!rst_sync_n)
      clk_en |=> ((io_out & $past(registered_cfg)) == (($past(out_reg_q) ^ $past(invert_cfg)) & $past(registered_cfg)));
  endproperty
  a_show: assert property (p_show) else $error("output not showing register");
  property p_polarity;
    @(posedge mclk) $rose(rst_sync_n) ##1 clk_en |->
      ((io_out & registered_cfg) == ($past(invert_cfg) & registered_cfg));
  endproperty
  a_polarity: assert property (p_polarity) else $error("reset pin level wrong");
  property p_comb;
    @(posedge mclk) disable iff (!rst_sync_n)
      clk_en |=> ((io_out & ~$past(registered_cfg)) == (($past(comb_d) ^ $past(invert_cfg)) & ~$past(registered_cfg)));
  endproperty
  a_comb: assert property (p_comb) else $error("combinational output disturbed");
  property p_hold_setup;
    @(posedge mclk) disable iff (!rst_sync_n)
      !setup_ready |=> $stable(out_reg_q);
  endproperty
  a_hold_setup: assert property (p_hold_setup) else $error("register moved before setup");
endmodule
`default_nettype wire

// ### pin_tester.sv
/*
  Tester model that drives one output pin during preload.
  Assumes the bench sets drive enable, target and level.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_tester (
  input wire logic drv_en,
  input wire logic [9:0] drv_sel,
  input wire logic drv_val,
  input wire logic [9:0] io_out,
  input wire logic [9:0] io_oe,
  output logic [9:0] io_in
);
  // Undriven pins show the device level when io_oe is set, else its inverse
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      if (drv_en && drv_sel[i])
        io_in[i] = drv_val;
      else if (io_oe[i])
        io_in[i] = io_out[i];
      else
        io_in[i] = ~io_out[i];
    end
  end
endmodule
`default_nettype wire

// ### tb_output_register_preload_init.sv
/*
  Bench for preload, power-up clear and normal clocking.
  Assumes the pin tester model and a 125 MHz mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_output_register_preload_init
  import preload_pkg::*;
;
  logic mclk = 0, rst_n = 0, dclk = 0, sv = 0, drv_en = 0, drv_val = 0, ready;
  logic [9:0] sel = 0, arr = 0, comb = 0, reg_cfg = 10'h3FF, inv = 0;
  logic [9:0] io_in, io_out, io_oe, q, exp_q;
  int errors = 0, cmp_count = 0, seed = 32'hc924, idx;
  output_register_preload_init i_output_register_preload_init (.mclk(mclk), .rst_n(rst_n),
    .clk_en(1'b1), .dev_clk_pin(dclk), .preload_supervoltage_level(sv), .preload_sel(sel),
    .io_in(io_in), .array_d(arr), .comb_d(comb), .registered_cfg(reg_cfg), .invert_cfg(inv),
    .oe_term(10'h3FF), .io_out(io_out), .io_oe(io_oe), .out_reg_q(q), .setup_ready(ready));
  pin_tester i_pin_tester (.drv_en(drv_en), .drv_sel(sel), .drv_val(drv_val),
    .io_out(io_out), .io_oe(io_oe), .io_in(io_in));
  initial forever #4 mclk = ~mclk;
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pulse;
    dclk = 1;
    cyc(6);
    dclk = 0;
    cyc(6);
  endtask
  task automatic give_verdict;
    $display("errors=%0d cmp_count=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    give_verdict();
  end
  initial begin
    inv = 10'($random(seed));
    comb = 10'($random(seed));
    exp_q = OUT_REG_RST;
    cyc(16);
    rst_n = 1;
    for (idx = 0; idx < 50 && ready !== 1'b1; idx++)
      cyc(1);
    if (ready !== 1'b1)
      errors++;
    cyc(2);
    cmp(q, exp_q);
    cmp(io_out, exp_q ^ inv);
    repeat (12) begin
      idx = {$random(seed)} % 10;
      sel = 10'h001 << idx;
      drv_val = 1'($random(seed));
      arr = 10'($random(seed));
      reg_cfg = 10'($random(seed)) | 10'h201;
      sv = 1;
      cyc(6);
      drv_en = 1;
      cyc(6);
      cmp(io_oe & reg_cfg, 10'h000);
      pulse();
      drv_en = 0;
      cyc(6);
      sv = 0;
      cyc(8);
      if (reg_cfg[idx])
        exp_q[idx] = drv_val;
      cmp(q, exp_q);
      cmp(io_out & reg_cfg, (exp_q ^ inv) & reg_cfg);
      cmp(io_oe, 10'h3FF);
    end
    repeat (8) begin
      arr = 10'($random(seed));
      drv_en = 1;
      pulse();
      exp_q = arr;
      cmp(q & reg_cfg, exp_q & reg_cfg);
    end
    drv_en = 0;
    rst_n = 0;
    cyc(2);
    cmp(q & reg_cfg, OUT_REG_RST);
    rst_n = 1;
    arr = 10'h3FF;
    for (idx = 0; idx < 50 && ready !== 1'b1; idx++)
      cyc(1);
    if (ready !== 1'b1)
      errors++;
    cyc(2);
    cmp(q, OUT_REG_RST);
    pulse();
    cmp(q, 10'h3FF);
    give_verdict();
  end
endmodule
`default_nettype wire
